// ### design/pll_lock_cfg.svh
// Holds the reset values, field sizes and timing counts of the PLL lock detector.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef PLL_LOCK_CFG_SVH
`define PLL_LOCK_CFG_SVH

// ----------------------------------------------------------------
// Ratio and qualification fields
// ----------------------------------------------------------------
`define PRESCALE_W 5
`define QUAL_SEL_W 4
`define QUAL_STEP 16
`define QUAL_CNT_W 9
`define OUT_DIV_COUNT 5

// ----------------------------------------------------------------
// Timing, in nanoseconds and in phase-detector clock cycles
// ----------------------------------------------------------------
`define CLOCK_PERIOD_NS 8
`define PHASE_WIN_NS 16
`define PHASE_WIN_CYC ((`PHASE_WIN_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define REF_LOSS_CYC 1024
`define GAP_CNT_W 16

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LOCK_N_RESET 1'b1
`define DIV_OUT_RESET 1'b0

`endif

// ### design/pll_lock_pkg.sv
// Holds the types shared by the PLL lock detector modules.
// Assumes the constants header is on the include path.
`include "pll_lock_cfg.svh"

package pll_lock_pkg;

   // ----------------------------------------------------------------
   // Modes
   // ----------------------------------------------------------------
   typedef enum logic [0:0] {
      MODE_PHASE = 1'b0,
      MODE_FREQ = 1'b1
   } lock_mode_e;

   typedef enum logic [2:0] {
      FQ_IDLE = 3'b001,
      FQ_QUAL = 3'b010,
      FQ_LOCKED = 3'b100
   } freq_state_e;

   // ----------------------------------------------------------------
   // Stored configuration
   // ----------------------------------------------------------------
   typedef struct packed {
      lock_mode_e mode;
      logic [`QUAL_SEL_W-1:0] qual_sel;
      logic [`PRESCALE_W-1:0] in_ratio_m1;
      logic [`PRESCALE_W-1:0] fb_ratio_m1;
      logic [`OUT_DIV_COUNT*`PRESCALE_W-1:0] out_half_m1;
   } lock_cfg_s;

   // ----------------------------------------------------------------
   // Detector status
   // ----------------------------------------------------------------
   typedef struct packed {
      logic phase_lock;
      logic freq_lock;
      logic resync;
   } lock_stat_s;

endpackage

// ### design/ratio_divider.sv
// Holds an integer event divider: one output pulse every ratio_m1+1 input events.
// Assumes tick_in is a one-cycle pulse on the same clock.
module ratio_divider #(
   parameter int W = 5
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic clear,
   input wire logic tick_in,
   input wire logic [W-1:0] ratio_m1,
   output logic tick_out
);

   logic [W-1:0] count;
   logic [W-1:0] next_count;
   wire at_end = (count >= ratio_m1);
   wire fire = tick_in && at_end && !clear;

   if (W < 1 || W > 16)
   begin : g_bad_width
      $error("ratio_divider width out of range");
   end

   assign next_count = clear ? '0 : (tick_in ? (at_end ? '0 : W'(count + 1'b1)) : count);

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         count <= '0;
         tick_out <= 1'b0;
      end
      else
      begin
         count <= next_count;
         tick_out <= fire;
      end
   end

endmodule // ratio_divider

// ### design/pll_lock_detector.sv
// Holds the lock detector of the PLL phase/frequency detector, with prescalers and output dividers.
// Assumes ref, feedback and VCO clocks arrive as pins; configuration is static after reset.
`include "pll_lock_cfg.svh"

module pll_lock_detector #(
   parameter int PHASE_WIN = `PHASE_WIN_CYC,
   parameter int REF_LOSS = `REF_LOSS_CYC
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic ref_clk_pin,
   input wire logic fbk_clk_pin,
   input wire logic vco_clk_pin,
   input wire pll_lock_pkg::lock_cfg_s cfg,
   output logic lock_n,
   output logic [`OUT_DIV_COUNT-1:0] div_out,
   output pll_lock_pkg::lock_stat_s status
);

   if (PHASE_WIN < 1 || PHASE_WIN >= REF_LOSS || REF_LOSS >= (1 << `GAP_CNT_W))
   begin : g_bad_timing
      $error("pll_lock_detector timing parameters out of range");
   end

   // ----------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ----------------------------------------------------------------
   logic [2:0] sync_a;
   logic [2:0] sync_b;
   logic [2:0] sync_c;
   wire [2:0] pins = {vco_clk_pin, fbk_clk_pin, ref_clk_pin};
   wire [2:0] rise = sync_b & ~sync_c;
   wire ref_edge = rise[0];
   wire fbk_edge = rise[1];
   wire vco_edge = rise[2];

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         sync_a <= '0;
         sync_b <= '0;
         sync_c <= '0;
      end
      else
      begin
         sync_a <= pins;
         sync_b <= sync_a;
         sync_c <= sync_b;
      end
   end

   // ----------------------------------------------------------------
   // Input and feedback prescalers
   // ----------------------------------------------------------------
   logic ref_tick;
   logic fbk_tick;

   ratio_divider #(.W(`PRESCALE_W)) u_in_prescale (
      .clock(clock),
      .rst(rst),
      .clear(1'b0),
      .tick_in(ref_edge),
      .ratio_m1(cfg.in_ratio_m1),
      .tick_out(ref_tick)
   );

   ratio_divider #(.W(`PRESCALE_W)) u_fb_prescale (
      .clock(clock),
      .rst(rst),
      .clear(1'b0),
      .tick_in(fbk_edge),
      .ratio_m1(cfg.fb_ratio_m1),
      .tick_out(fbk_tick)
   );

   // ----------------------------------------------------------------
   // Phase-match detector
   // ----------------------------------------------------------------
   logic [`GAP_CNT_W-1:0] since_ref;
   logic [`GAP_CNT_W-1:0] since_fbk;
   logic phase_lock;
   logic next_phase_lock;
   wire ref_recent = (since_ref < `GAP_CNT_W'(PHASE_WIN));
   wire fbk_recent = (since_fbk < `GAP_CNT_W'(PHASE_WIN));
   wire ref_lost = !ref_tick && (since_ref >= `GAP_CNT_W'(REF_LOSS));
   wire both_tick = ref_tick && fbk_tick;
   wire ref_alone = ref_tick && !fbk_tick;
   wire fbk_alone = fbk_tick && !ref_tick;
   wire phase_hit = both_tick || (ref_alone && fbk_recent) || (fbk_alone && ref_recent);
   wire phase_miss = (ref_alone && !fbk_recent) || (fbk_alone && !ref_recent);

   assign next_phase_lock = ref_lost ? 1'b0 :
                            phase_miss ? 1'b0 :
                            phase_hit ? 1'b1 : phase_lock;

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         since_ref <= '1;
         since_fbk <= '1;
         phase_lock <= 1'b0;
      end
      else
      begin
         since_ref <= ref_tick ? '0 : ((&since_ref) ? since_ref : `GAP_CNT_W'(since_ref + 1'b1));
         since_fbk <= fbk_tick ? '0 : ((&since_fbk) ? since_fbk : `GAP_CNT_W'(since_fbk + 1'b1));
         phase_lock <= next_phase_lock;
      end
   end

   // ----------------------------------------------------------------
   // Frequency-match detector
   // ----------------------------------------------------------------
   pll_lock_pkg::freq_state_e fq_state;
   pll_lock_pkg::freq_state_e next_fq_state;
   logic [1:0] fbk_per_ref;
   logic [`QUAL_CNT_W-1:0] qual_cnt;
   logic [`QUAL_CNT_W-1:0] next_qual_cnt;
   logic resync;
   wire [`QUAL_CNT_W-1:0] qual_target = `QUAL_CNT_W'((cfg.qual_sel + 1) * `QUAL_STEP);
   wire fbk_over = fbk_tick && (fbk_per_ref != 2'd0) && !ref_tick;
   wire period_ok = ref_tick && (fbk_tick ? (fbk_per_ref == 2'd0) : (fbk_per_ref == 2'd1));
   wire freq_miss = fbk_over || (ref_tick && !period_ok);
   wire qual_done = period_ok && (qual_cnt + 1'b1 >= {1'b0, qual_target});
   wire fq_rise = (fq_state != pll_lock_pkg::FQ_LOCKED) && (next_fq_state == pll_lock_pkg::FQ_LOCKED);

   always_comb
   begin
      next_fq_state = fq_state;
      next_qual_cnt = qual_cnt;
      unique case (fq_state)
         pll_lock_pkg::FQ_IDLE:
         begin
            next_qual_cnt = '0;
            if (period_ok)
            begin
               next_fq_state = pll_lock_pkg::FQ_QUAL;
               next_qual_cnt = `QUAL_CNT_W'(1);
            end
         end
         pll_lock_pkg::FQ_QUAL:
         begin
            if (freq_miss)
            begin
               next_fq_state = pll_lock_pkg::FQ_IDLE;
               next_qual_cnt = '0;
            end
            else if (qual_done)
            begin
               next_fq_state = pll_lock_pkg::FQ_LOCKED;
               next_qual_cnt = '0;
            end
            else if (period_ok)
               next_qual_cnt = `QUAL_CNT_W'(qual_cnt + 1'b1);
         end
         pll_lock_pkg::FQ_LOCKED:
         begin
            next_qual_cnt = '0;
            if (freq_miss)
               next_fq_state = pll_lock_pkg::FQ_IDLE;
         end
         default:
         begin
            next_fq_state = pll_lock_pkg::FQ_IDLE;
            next_qual_cnt = '0;
         end
      endcase
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         fq_state <= pll_lock_pkg::FQ_IDLE;
         qual_cnt <= '0;
         fbk_per_ref <= '0;
         resync <= 1'b0;
      end
      else
      begin
         fq_state <= next_fq_state;
         qual_cnt <= next_qual_cnt;
         fbk_per_ref <= ref_tick ? 2'd0 : ((fbk_tick && fbk_per_ref != 2'd3) ? 2'(fbk_per_ref + 1'b1) : fbk_per_ref);
         resync <= fq_rise;
      end
   end

   // ----------------------------------------------------------------
   // Output dividers
   // ----------------------------------------------------------------
   logic [`OUT_DIV_COUNT-1:0] half_tick;

   genvar k;
   generate
      for (k = 0; k < `OUT_DIV_COUNT; k++)
      begin : g_out_div
         ratio_divider #(.W(`PRESCALE_W)) u_out_div (
            .clock(clock),
            .rst(rst),
            .clear(resync),
            .tick_in(vco_edge),
            .ratio_m1(cfg.out_half_m1[k*`PRESCALE_W +: `PRESCALE_W]),
            .tick_out(half_tick[k])
         );

         always_ff @(posedge clock or posedge rst)
         begin
            if (rst)
               div_out[k] <= `DIV_OUT_RESET;
            else if (resync)
               div_out[k] <= `DIV_OUT_RESET;
            else if (half_tick[k])
               div_out[k] <= ~div_out[k];
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Lock pin selection
   // ----------------------------------------------------------------
   wire sel_next = (cfg.mode == pll_lock_pkg::MODE_FREQ) ? (next_fq_state == pll_lock_pkg::FQ_LOCKED)
                                                         : next_phase_lock;

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         lock_n <= `LOCK_N_RESET;
         status <= '0;
      end
      else
      begin
         lock_n <= ~sel_next;
         status <= '{phase_lock: next_phase_lock, freq_lock: (next_fq_state == pll_lock_pkg::FQ_LOCKED),
                     resync: fq_rise};
      end
   end

endmodule // pll_lock_detector

// ### sim/pll_lock_detector_properties.sv
// Concurrent checks on the pins of the PLL lock detector.
// Assumes binding into pll_lock_detector; sees its ports only.
`include "pll_lock_cfg.svh"
module pll_lock_checks #(
   parameter int PHASE_WIN = 2,
   parameter int REF_LOSS = 1024
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic ref_clk_pin,
   input wire logic fbk_clk_pin,
   input wire logic vco_clk_pin,
   input wire pll_lock_pkg::lock_cfg_s cfg,
   input wire logic lock_n,
   input wire logic [`OUT_DIV_COUNT-1:0] div_out,
   input wire pll_lock_pkg::lock_stat_s status
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_d;
   logic fbk_d;
   logic [9:0] ref_edges;
   logic [15:0] ref_quiet;
   logic [3:0] edge_age;
   wire logic ref_rise = ref_clk_pin & ~ref_d;
   wire logic any_rise = ref_rise | (fbk_clk_pin & ~fbk_d);
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         ref_d <= 1'b0;
         fbk_d <= 1'b0;
         ref_edges <= 10'h000;
         ref_quiet <= 16'h0000;
         edge_age <= 4'hf;
      end
      else
      begin
         ref_d <= ref_clk_pin;
         fbk_d <= fbk_clk_pin;
         ref_edges <= status.freq_lock ? 10'h000 : ref_edges + {9'h000, ref_rise & (ref_edges != 10'h3ff)};
         ref_quiet <= (ref_clk_pin != ref_d) ? 16'h0000 : ref_quiet + {15'h0000, ref_quiet != 16'hffff};
         edge_age <= any_rise ? 4'h0 : edge_age + {3'h0, edge_age != 4'hf};
      end
   end
   // -----
   // Assertions
   // -----
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   property p_pin;
      lock_n == ((cfg.mode == pll_lock_pkg::MODE_FREQ) ? !status.freq_lock : !status.phase_lock);
   endproperty
   a_pin: assert property (p_pin)
      else $error("lock pin differs from selected detector");
   property p_rs_on;
      $rose(status.freq_lock) |-> status.resync;
   endproperty
   a_rs_on: assert property (p_rs_on)
      else $error("no resync with frequency lock");
   property p_rs_clr;
      status.resync |=> div_out == 5'h00;
   endproperty
   a_rs_clr: assert property (p_rs_clr)
      else $error("dividers not cleared by resync");
   property p_rs_one;
      status.resync |=> !status.resync;
   endproperty
   a_rs_one: assert property (p_rs_one)
      else $error("resync longer than one cycle");
   property p_qual;
      $rose(status.freq_lock) |-> int'(ref_edges) >= 16 * (int'(cfg.qual_sel) + 1);
   endproperty
   a_qual: assert property (p_qual)
      else $error("frequency lock before qualification count");
   property p_loss;
      (int'(ref_quiet) > REF_LOSS + 8) |-> !status.phase_lock;
   endproperty
   a_loss: assert property (p_loss)
      else $error("phase lock held without reference");
   property p_hit;
      ($rose(ref_clk_pin) && $rose(fbk_clk_pin) && cfg.in_ratio_m1 == 5'h00 && cfg.fb_ratio_m1 == 5'h00)
         |-> ##[1:8] status.phase_lock;
   endproperty
   a_hit: assert property (p_hit)
      else $error("coincident edges gave no phase lock");
   property p_edge;
      $rose(status.phase_lock) |-> int'(edge_age) <= PHASE_WIN + 8;
   endproperty
   a_edge: assert property (p_edge)
      else $error("phase lock rose without a clock edge");
endmodule // pll_lock_checks

bind pll_lock_detector pll_lock_checks #(.PHASE_WIN(PHASE_WIN), .REF_LOSS(REF_LOSS)) u_pll_lock_checks (
   .clock(clock), .rst(rst), .ref_clk_pin(ref_clk_pin), .fbk_clk_pin(fbk_clk_pin), .vco_clk_pin(vco_clk_pin),
   .cfg(cfg), .lock_n(lock_n), .div_out(div_out), .status(status));

// ### sim/lock_monitor_model.sv
// Board logic watching the lock pin; flags clocks stable after a settle wait.
// Assumes the lock pin is sampled on the detector clock.
module lock_monitor_model #(
   parameter int WAIT_CYC = 100
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic lock_n,
   output logic clocks_stable
);
   timeunit 1ns;
   timeprecision 1ps;
   int settle;
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         settle <= 0;
      else if (lock_n)
         settle <= 0;
      else if (settle < WAIT_CYC)
         settle <= settle + 1;
   end
   assign clocks_stable = (settle >= WAIT_CYC);
endmodule // lock_monitor_model

// ### sim/pll_lock_detector_test.sv
// Self-checking bench of the PLL lock detector, one task per scenario.
// Assumes package, header, checker and monitor model are compiled first.
`include "pll_lock_cfg.svh"
module pll_lock_detector_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock;
   logic rst;
   logic ref_clk_pin;
   logic fbk_clk_pin;
   logic [1:0] vco_cnt;
   pll_lock_pkg::lock_cfg_s cfg;
   logic lock_n;
   logic [`OUT_DIV_COUNT-1:0] div_out;
   pll_lock_pkg::lock_stat_s status;
   logic clocks_stable;
   int bad_count;
   int cmp_count;
   pll_lock_detector #(.REF_LOSS(64)) u_pll_lock_detector (.clock(clock), .rst(rst), .ref_clk_pin(ref_clk_pin),
      .fbk_clk_pin(fbk_clk_pin), .vco_clk_pin(vco_cnt[1]), .cfg(cfg), .lock_n(lock_n), .div_out(div_out),
      .status(status));
   lock_monitor_model #(.WAIT_CYC(100)) u_lock_monitor_model (.clock(clock), .rst(rst), .lock_n(lock_n),
      .clocks_stable(clocks_stable));
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   always @(posedge clock)
      vco_cnt <= vco_cnt + 2'h1;
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Pin pulses, eight detector cycles each
   task automatic pulse(input logic r, input logic f, input int n);
      repeat (n)
      begin
         @(posedge clock);
         ref_clk_pin <= r;
         fbk_clk_pin <= f;
         repeat (4) @(posedge clock);
         ref_clk_pin <= 1'b0;
         fbk_clk_pin <= 1'b0;
         repeat (3) @(posedge clock);
      end
      @(negedge clock);
   endtask
   task automatic restart(input pll_lock_pkg::lock_mode_e mode, input logic [`QUAL_SEL_W-1:0] q);
      @(posedge clock);
      rst <= 1'b1;
      cfg.mode <= mode;
      cfg.qual_sel <= q;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      @(negedge clock);
   endtask
   task automatic t_reset_div;
      int rises [`OUT_DIV_COUNT];
      logic [`OUT_DIV_COUNT-1:0] prev;
      restart(pll_lock_pkg::MODE_PHASE, 4'h0);
      check("lock_n", lock_n, 1'b1);
      check("div_out", div_out, 5'h00);
      check("status", status, 3'h0);
      prev = div_out;
      foreach (rises[k]) rises[k] = 0;
      repeat (480)
      begin
         @(negedge clock);
         foreach (rises[k]) rises[k] += int'(div_out[k] & ~prev[k]);
         prev = div_out;
      end
      foreach (rises[k]) check("rate", 16'(rises[k] * (k + 1) >= 59 - k && rises[k] * (k + 1) <= 61 + k), 1);
      $display("test reset and dividers done");
   endtask
   task automatic t_phase;
      restart(pll_lock_pkg::MODE_PHASE, 4'h0);
      pulse(1'b1, 1'b1, 2);
      check("lock_n", lock_n, 1'b0);
      pulse(1'b1, 1'b1, 17);
      check("freq_lock", status.freq_lock, 1'b1);
      check("lock_n", lock_n, 1'b0);
      check("stable", clocks_stable, 1'b1);
      pulse(1'b0, 1'b1, 2);
      check("lock_n", lock_n, 1'b1);
      check("stable", clocks_stable, 1'b0);
      $display("test phase mode done");
   endtask
   task automatic t_freq(input logic [`QUAL_SEL_W-1:0] q);
      int n;
      n = 16 * (int'(q) + 1);
      restart(pll_lock_pkg::MODE_FREQ, q);
      pulse(1'b1, 1'b1, n - 1);
      check("lock_n", lock_n, 1'b1);
      pulse(1'b1, 1'b1, 2);
      check("lock_n", lock_n, 1'b0);
      pulse(1'b0, 1'b1, 1);
      pulse(1'b1, 1'b1, 1);
      check("lock_n", lock_n, 1'b1);
      pulse(1'b1, 1'b1, n - 2);
      check("lock_n", lock_n, 1'b1);
      pulse(1'b1, 1'b1, 3);
      check("lock_n", lock_n, 1'b0);
      repeat (200) @(negedge clock);
      check("lock_n", lock_n, 1'b0);
      check("phase_lock", status.phase_lock, 1'b0);
      $display("test frequency mode done");
   endtask
   task automatic t_prescale;
      @(posedge clock);
      cfg.in_ratio_m1 <= 5'h01;
      restart(pll_lock_pkg::MODE_PHASE, 4'h0);
      pulse(1'b1, 1'b0, 1);
      pulse(1'b1, 1'b1, 1);
      pulse(1'b1, 1'b0, 1);
      check("lock_n", lock_n, 1'b0);
      @(posedge clock);
      cfg.in_ratio_m1 <= 5'h00;
      cfg.fb_ratio_m1 <= 5'h01;
      restart(pll_lock_pkg::MODE_PHASE, 4'h0);
      pulse(1'b0, 1'b1, 1);
      pulse(1'b1, 1'b1, 1);
      pulse(1'b0, 1'b1, 1);
      check("lock_n", lock_n, 1'b0);
      $display("test prescalers done");
   endtask
   initial
   begin
      bad_count = 0;
      cmp_count = 0;
      vco_cnt = 2'h0;
      rst = 1'b1;
      ref_clk_pin = 1'b0;
      fbk_clk_pin = 1'b0;
      cfg = '0;
      cfg.out_half_m1 = {5'h04, 5'h03, 5'h02, 5'h01, 5'h00};
      t_reset_div();
      t_phase();
      t_freq(4'h0);
      t_freq(4'hf);
      t_prescale();
      conclude();
   end
   initial
   begin
      #400000;
      bad_count++;
      $display("CHECK FAILED run length expected end seen hang");
      conclude();
   end
endmodule // pll_lock_detector_test
